// >>> fault_limits_defines.vh
// command codes, reset values, lengths and status bit positions of the fault limit bank
`ifndef FAULT_LIMITS_DEFINES_VH
`define FAULT_LIMITS_DEFINES_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_OUT_OV_LIMIT     8'h40
`define CMD_OUT_UV_LIMIT     8'h44
`define CMD_STAGE_OT_LIMIT   8'h4F
`define CMD_OVERTEMP_WARNING_LIMIT    8'h51
`define CMD_IN_OV_LIMIT      8'h55
`define CMD_IN_UV_LIMIT      8'h59
`define CMD_COMMIT_SETTINGS  8'hE7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_OUT_OV_LIMIT     16'h076C
`define RST_OUT_UV_LIMIT     16'h0000
`define RST_STAGE_OT_LIMIT   16'h007D
`define RST_OVERTEMP_WARNING_LIMIT    16'h07D0
`define RST_IN_OV_LIMIT      16'h36B0
`define RST_IN_UV_LIMIT      16'h1F40

// ----------------------------------------------------------------
// transfer lengths in data bytes
// ----------------------------------------------------------------
`define LIMIT_DATA_BYTES     2'h2
`define COMMIT_DATA_BYTES    2'h0

// ----------------------------------------------------------------
// summary status byte bit positions
// ----------------------------------------------------------------
`define SUM_BIT_TEMPERATURE  2
`define SUM_BIT_INPUT        3
`define SUM_BIT_OUTPUT_OV    5
`define SUM_BIT_OUTPUT       7

// ----------------------------------------------------------------
// per page temperature status bit positions
// ----------------------------------------------------------------
`define TEMP_BIT_OT_WARN     6
`define TEMP_BIT_OT_FAULT    7

`endif

// >>> fault_threshold_registers.v
// fault and warning limit registers with their comparators and status outputs
//
// Operation
// - per page output overvoltage limit, reset 076Ch
// - ov and input limits act after commit
// - output undervoltage masked while ramping or disabled
// - per page output undervoltage limit, reset 0000h
// - per page signed stage overtemp limit, 007Dh
// - warning sets summary and temperature status flags
// - warning asserts alert and thermal warn pins
// - per page signed overtemp warning limit, 07D0h
// - shared input overvoltage limit, reset 36B0h
// - input undervoltage limit is the lockout level
// - shared input undervoltage limit, reset 1F40h
// - two data bytes; input limits unpaged
// - either output's fault shows in summary byte
`timescale 1ns/1ps
`include "fault_limits_defines.vh"

module fault_threshold_registers #(
    parameter PAGES = 2,
    parameter DW    = 16
) (
    input  wire                clk_i,
    input  wire                srst_i,
    input  wire                ce_i,
    input  wire                cmd_valid_i,
    input  wire                cmd_write_i,
    input  wire [7:0]          cmd_code_i,
    input  wire [1:0]          cmd_len_i,
    input  wire                cmd_page_i,
    input  wire [DW-1:0]       cmd_wdata_i,
    output reg                 rsp_valid_o,
    output reg                 rsp_err_o,
    output reg  [DW-1:0]       rsp_rdata_o,
    input  wire [PAGES*DW-1:0] vout_meas_i,
    input  wire [PAGES*DW-1:0] temp_meas_i,
    input  wire [DW-1:0]       vin_meas_i,
    input  wire [PAGES-1:0]    out_enable_i,
    input  wire [PAGES-1:0]    out_ramp_i,
    output reg  [PAGES-1:0]    vout_ov_o,
    output reg  [PAGES-1:0]    vout_uv_o,
    output reg  [PAGES-1:0]    ot_fault_o,
    output reg  [PAGES-1:0]    ot_warn_o,
    output reg                 vin_ov_o,
    output reg                 vin_lockout_o,
    output reg  [7:0]          status_byte_o,
    output reg  [15:0]         status_word_o,
    output reg  [PAGES*8-1:0]  temp_status_o,
    output reg                 alert_o,
    output reg                 thermal_warn_o
);

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire       acc;
    wire       is_ov;
    wire       is_uv;
    wire       is_otf;
    wire       is_otw;
    wire       is_vin_ov;
    wire       is_vin_uv;
    wire       is_commit;
    wire       is_limit;
    wire       len_two;
    wire       wr_ok;
    wire       rd_ok;
    wire       commit_ok;
    wire [4:0] sel;

    // a request is taken only while the clock enable is high
    assign acc       = ce_i & cmd_valid_i;
    assign is_ov     = (cmd_code_i == `CMD_OUT_OV_LIMIT);
    assign is_uv     = (cmd_code_i == `CMD_OUT_UV_LIMIT);
    assign is_otf    = (cmd_code_i == `CMD_STAGE_OT_LIMIT);
    assign is_otw    = (cmd_code_i == `CMD_OVERTEMP_WARNING_LIMIT);
    assign is_vin_ov = (cmd_code_i == `CMD_IN_OV_LIMIT);
    assign is_vin_uv = (cmd_code_i == `CMD_IN_UV_LIMIT);
    assign is_commit = (cmd_code_i == `CMD_COMMIT_SETTINGS);
    assign is_limit  = is_ov | is_uv | is_otf | is_otw | is_vin_ov | is_vin_uv;

    // limit transfers carry exactly two data bytes
    assign len_two   = (cmd_len_i == `LIMIT_DATA_BYTES);
    assign wr_ok     = acc & cmd_write_i & is_limit & len_two;
    assign rd_ok     = acc & ~cmd_write_i & is_limit & len_two;
    assign commit_ok = acc & cmd_write_i & is_commit &
                       (cmd_len_i == `COMMIT_DATA_BYTES);

    // base bit of the selected page inside the packed per page vectors
    assign sel = {cmd_page_i, 4'h0};

    // ----------------------------------------------------------------
    // limit storage
    // ----------------------------------------------------------------
    reg [PAGES*DW-1:0] ov_pend_q;
    reg [PAGES*DW-1:0] ov_act_q;
    reg [PAGES*DW-1:0] uv_q;
    reg [PAGES*DW-1:0] otf_q;
    reg [PAGES*DW-1:0] otw_q;
    reg [DW-1:0]       vin_ov_pend_q;
    reg [DW-1:0]       vin_ov_act_q;
    reg [DW-1:0]       vin_uv_pend_q;
    reg [DW-1:0]       vin_uv_act_q;

    // written values; commit copies the pending values into the active set
    always @(posedge clk_i) begin
        if (srst_i) begin
            ov_pend_q     <= {PAGES{`RST_OUT_OV_LIMIT}};
            ov_act_q      <= {PAGES{`RST_OUT_OV_LIMIT}};
            uv_q          <= {PAGES{`RST_OUT_UV_LIMIT}};
            otf_q         <= {PAGES{`RST_STAGE_OT_LIMIT}};
            otw_q         <= {PAGES{`RST_OVERTEMP_WARNING_LIMIT}};
            vin_ov_pend_q <= `RST_IN_OV_LIMIT;
            vin_ov_act_q  <= `RST_IN_OV_LIMIT;
            vin_uv_pend_q <= `RST_IN_UV_LIMIT;
            vin_uv_act_q  <= `RST_IN_UV_LIMIT;
        end else if (ce_i) begin
            if (wr_ok) begin
                // output and temperature limits kept per page
                if (is_ov) begin
                    ov_pend_q[sel +: DW] <= cmd_wdata_i;
                end
                if (is_uv) begin
                    uv_q[sel +: DW] <= cmd_wdata_i;
                end
                if (is_otf) begin
                    otf_q[sel +: DW] <= cmd_wdata_i;
                end
                if (is_otw) begin
                    otw_q[sel +: DW] <= cmd_wdata_i;
                end
                // input limits ignore the page
                if (is_vin_ov) begin
                    vin_ov_pend_q <= cmd_wdata_i;
                end
                if (is_vin_uv) begin
                    vin_uv_pend_q <= cmd_wdata_i;
                end
            end
            // previous active values stay in force until commit
            if (commit_ok) begin
                ov_act_q     <= ov_pend_q;
                vin_ov_act_q <= vin_ov_pend_q;
                vin_uv_act_q <= vin_uv_pend_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    reg [DW-1:0] rd_mux;

    // reads return the last written value, committed or not
    always @* begin
        rd_mux = {DW{1'b0}};
        case (1'b1)
            is_ov:     rd_mux = ov_pend_q[sel +: DW];
            is_uv:     rd_mux = uv_q[sel +: DW];
            is_otf:    rd_mux = otf_q[sel +: DW];
            is_otw:    rd_mux = otw_q[sel +: DW];
            is_vin_ov: rd_mux = vin_ov_pend_q;
            is_vin_uv: rd_mux = vin_uv_pend_q;
            default:   rd_mux = {DW{1'b0}};
        endcase
    end

    // one cycle answer to every taken request
    always @(posedge clk_i) begin
        if (srst_i) begin
            rsp_valid_o <= 1'b0;
            rsp_err_o   <= 1'b0;
            rsp_rdata_o <= {DW{1'b0}};
        end else if (ce_i) begin
            rsp_valid_o <= acc;
            rsp_err_o   <= acc & ~(wr_ok | rd_ok | commit_ok);
            if (rd_ok) begin
                rsp_rdata_o <= rd_mux;
            end
        end
    end

    // ----------------------------------------------------------------
    // per page comparators
    // ----------------------------------------------------------------
    wire [PAGES-1:0] ov_hit;
    wire [PAGES-1:0] uv_hit;
    wire [PAGES-1:0] otf_hit;
    wire [PAGES-1:0] otw_hit;

    genvar p;
    generate
        for (p = 0; p < PAGES; p = p + 1) begin : pg
            // output voltage above the active overvoltage limit
            limit_compare #(
                .W      (DW),
                .SIGNED (0),
                .ABOVE  (1)
            ) u_ov (
                .value_i (vout_meas_i[p*DW +: DW]),
                .limit_i (ov_act_q[p*DW +: DW]),
                .hit_o   (ov_hit[p])
            );

            // output voltage below the undervoltage limit
            limit_compare #(
                .W      (DW),
                .SIGNED (0),
                .ABOVE  (0)
            ) u_uv (
                .value_i (vout_meas_i[p*DW +: DW]),
                .limit_i (uv_q[p*DW +: DW]),
                .hit_o   (uv_hit[p])
            );

            // signed temperature above the stage fault limit
            limit_compare #(
                .W      (DW),
                .SIGNED (1),
                .ABOVE  (1)
            ) u_otf (
                .value_i (temp_meas_i[p*DW +: DW]),
                .limit_i (otf_q[p*DW +: DW]),
                .hit_o   (otf_hit[p])
            );

            // signed temperature above the warning limit
            limit_compare #(
                .W      (DW),
                .SIGNED (1),
                .ABOVE  (1)
            ) u_otw (
                .value_i (temp_meas_i[p*DW +: DW]),
                .limit_i (otw_q[p*DW +: DW]),
                .hit_o   (otw_hit[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // input supply comparators
    // ----------------------------------------------------------------
    wire vin_ov_hit;
    wire vin_uv_hit;

    // input voltage above the active input overvoltage limit
    limit_compare #(
        .W      (DW),
        .SIGNED (0),
        .ABOVE  (1)
    ) u_vin_ov (
        .value_i (vin_meas_i),
        .limit_i (vin_ov_act_q),
        .hit_o   (vin_ov_hit)
    );

    // input voltage below the lockout level
    limit_compare #(
        .W      (DW),
        .SIGNED (0),
        .ABOVE  (0)
    ) u_vin_uv (
        .value_i (vin_meas_i),
        .limit_i (vin_uv_act_q),
        .hit_o   (vin_uv_hit)
    );

    // ----------------------------------------------------------------
    // fault flags and status
    // ----------------------------------------------------------------
    wire [PAGES-1:0] uv_live;
    wire             any_temp;
    wire             any_out;
    wire             any_in;
    reg  [7:0]       sum_d;
    reg  [PAGES*8-1:0] temp_d;
    integer          k;

    // undervoltage is ignored while disabled or ramping
    assign uv_live  = uv_hit & out_enable_i & ~out_ramp_i;
    assign any_temp = (|otw_hit) | (|otf_hit);
    assign any_out  = (|ov_hit) | (|uv_live);
    assign any_in   = vin_ov_hit | vin_uv_hit;

    // summary byte gathers both outputs
    always @* begin
        sum_d = 8'h00;
        sum_d[`SUM_BIT_TEMPERATURE] = any_temp;
        sum_d[`SUM_BIT_INPUT]       = any_in;
        sum_d[`SUM_BIT_OUTPUT_OV]   = |ov_hit;
        sum_d[`SUM_BIT_OUTPUT]      = any_out;
    end

    // per page temperature status
    always @* begin
        temp_d = {(PAGES*8){1'b0}};
        for (k = 0; k < PAGES; k = k + 1) begin
            temp_d[k*8 + `TEMP_BIT_OT_WARN]  = otw_hit[k];
            temp_d[k*8 + `TEMP_BIT_OT_FAULT] = otf_hit[k];
        end
    end

    // all flags and pins registered, live levels of the comparators
    always @(posedge clk_i) begin
        if (srst_i) begin
            vout_ov_o      <= {PAGES{1'b0}};
            vout_uv_o      <= {PAGES{1'b0}};
            ot_fault_o     <= {PAGES{1'b0}};
            ot_warn_o      <= {PAGES{1'b0}};
            vin_ov_o       <= 1'b0;
            vin_lockout_o  <= 1'b0;
            status_byte_o  <= 8'h00;
            status_word_o  <= 16'h0000;
            temp_status_o  <= {(PAGES*8){1'b0}};
            alert_o        <= 1'b0;
            thermal_warn_o <= 1'b0;
        end else if (ce_i) begin
            vout_ov_o      <= ov_hit;
            vout_uv_o      <= uv_live;
            ot_fault_o     <= otf_hit;
            ot_warn_o      <= otw_hit;
            vin_ov_o       <= vin_ov_hit;
            vin_lockout_o  <= vin_uv_hit;
            status_byte_o  <= sum_d;
            status_word_o  <= {8'h00, sum_d};
            temp_status_o  <= temp_d;
            alert_o        <= any_temp | any_out | any_in;
            thermal_warn_o <= |otw_hit;
        end
    end

endmodule

// >>> fault_threshold_registers_properties.sv
// port assertions for the fault limit bank
`timescale 1ns/1ps
`include "fault_limits_defines.vh"

module fault_threshold_registers_properties #(
    parameter PAGES = 2,
    parameter DW    = 16
) (
    input wire logic                clk_i,
    input wire logic                srst_i,
    input wire logic                ce_i,
    input wire logic                cmd_valid_i,
    input wire logic                cmd_write_i,
    input wire logic [7:0]          cmd_code_i,
    input wire logic [1:0]          cmd_len_i,
    input wire logic [DW-1:0]       cmd_wdata_i,
    input wire logic                rsp_valid_o,
    input wire logic                rsp_err_o,
    input wire logic [DW-1:0]       vin_meas_i,
    input wire logic [PAGES-1:0]    out_enable_i,
    input wire logic [PAGES-1:0]    out_ramp_i,
    input wire logic [PAGES-1:0]    vout_ov_o,
    input wire logic [PAGES-1:0]    vout_uv_o,
    input wire logic [PAGES-1:0]    ot_warn_o,
    input wire logic                vin_ov_o,
    input wire logic                vin_lockout_o,
    input wire logic [7:0]          status_byte_o,
    input wire logic [15:0]         status_word_o,
    input wire logic [PAGES*8-1:0]  temp_status_o,
    input wire logic                alert_o,
    input wire logic                thermal_warn_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // mirror of the committed input limits
    wire         good_wr = ce_i && cmd_valid_i && cmd_write_i && cmd_len_i == `LIMIT_DATA_BYTES;
    wire         commit  = ce_i && cmd_valid_i && cmd_write_i
                           && cmd_code_i == `CMD_COMMIT_SETTINGS && cmd_len_i == `COMMIT_DATA_BYTES;
    reg [DW-1:0] ov_pend_q, ov_act_q, uv_pend_q, uv_act_q;
    always @(posedge clk_i) begin
        if (srst_i) begin
            ov_pend_q <= `RST_IN_OV_LIMIT;
            ov_act_q  <= `RST_IN_OV_LIMIT;
            uv_pend_q <= `RST_IN_UV_LIMIT;
            uv_act_q  <= `RST_IN_UV_LIMIT;
        end else begin
            if (good_wr && cmd_code_i == `CMD_IN_OV_LIMIT) ov_pend_q <= cmd_wdata_i;
            if (good_wr && cmd_code_i == `CMD_IN_UV_LIMIT) uv_pend_q <= cmd_wdata_i;
            if (commit) begin
                ov_act_q <= ov_pend_q;
                uv_act_q <= uv_pend_q;
            end
        end
    end

    sequence req_s;
        ce_i && cmd_valid_i;
    endsequence
    sequence short_limit_s;
        req_s ##0 cmd_code_i == `CMD_OUT_OV_LIMIT && cmd_len_i != `LIMIT_DATA_BYTES;
    endsequence

    AST_RSP_AFTER_REQ: assert property (req_s |=> rsp_valid_o)
        else $error("no response after a request");
    AST_NO_STRAY_RSP: assert property (ce_i && !cmd_valid_i |=> !rsp_valid_o)
        else $error("response without a request");
    AST_ERR_SHORT_LEN: assert property (short_limit_s |=> rsp_valid_o && rsp_err_o)
        else $error("wrong length limit write not refused");
    AST_UV_MASKED: assert property (
        ce_i && (out_ramp_i[0] || !out_enable_i[0]) |=> !vout_uv_o[0])
        else $error("undervoltage flagged while masked");
    AST_WARN_STATUS: assert property (|ot_warn_o |-> status_byte_o[`SUM_BIT_TEMPERATURE]
        && status_word_o[`SUM_BIT_TEMPERATURE]
        && ot_warn_o[1] == temp_status_o[8+`TEMP_BIT_OT_WARN])
        else $error("warning missing from status");
    AST_WARN_PINS: assert property (|ot_warn_o |-> alert_o && thermal_warn_o)
        else $error("warning pins not raised");
    AST_OUT_SUMMARY: assert property (|vout_ov_o |-> status_byte_o[`SUM_BIT_OUTPUT]
        && status_byte_o[`SUM_BIT_OUTPUT_OV])
        else $error("output fault missing from summary");
    AST_VIN_OV_ACTIVE: assert property (
        ce_i |=> vin_ov_o == ($past(vin_meas_i) > $past(ov_act_q)))
        else $error("input overvoltage flag off committed limit");
    AST_LOCKOUT: assert property (
        ce_i |=> vin_lockout_o == ($past(vin_meas_i) < $past(uv_act_q)))
        else $error("lockout flag off committed limit");
endmodule

// >>> limit_compare.v
// threshold comparator, signed or unsigned, above or below
`timescale 1ns/1ps

module limit_compare #(
    parameter W      = 16,
    parameter SIGNED = 0,
    parameter ABOVE  = 1
) (
    input  wire [W-1:0] value_i,
    input  wire [W-1:0] limit_i,
    output wire         hit_o
);

    // ----------------------------------------------------------------
    // comparisons
    // ----------------------------------------------------------------
    wire gt_s;
    wire gt_u;
    wire lt_s;
    wire lt_u;

    // both encodings evaluated, parameter picks one
    assign gt_s = $signed(value_i) > $signed(limit_i);
    assign gt_u = value_i > limit_i;
    assign lt_s = $signed(value_i) < $signed(limit_i);
    assign lt_u = value_i < limit_i;

    // rising limits fire above, falling limits below
    assign hit_o = (ABOVE != 0) ? ((SIGNED != 0) ? gt_s : gt_u)
                                : ((SIGNED != 0) ? lt_s : lt_u);

endmodule

// >>> limit_host_model.sv
// host model driving the limit bank command port
`timescale 1ns/1ps

module limit_host_model (
    input  wire        clk_i,
    input  wire        rsp_valid_i,
    input  wire        rsp_err_i,
    input  wire [15:0] rsp_rdata_i,
    output reg         cmd_valid_o,
    output reg         cmd_write_o,
    output reg  [7:0]  cmd_code_o,
    output reg  [1:0]  cmd_len_o,
    output reg         cmd_page_o,
    output reg  [15:0] cmd_wdata_o
);
    // idle request lines
    initial begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_len_o   = 2'h0;
        cmd_page_o  = 1'b0;
        cmd_wdata_o = 16'h0000;
    end

    // one transfer; callers keep temperature and input limits in range
    task xfer(input logic wr, input logic [7:0] code, input logic [1:0] len, input logic pg,
              input logic [15:0] d, output logic v, output logic e, output logic [15:0] q);
        begin
            @(negedge clk_i);
            cmd_valid_o = 1'b1;
            cmd_write_o = wr;
            cmd_code_o  = code;
            cmd_len_o   = len;
            cmd_page_o  = pg;
            cmd_wdata_o = d;
            @(negedge clk_i);
            v = rsp_valid_i;
            e = rsp_err_i;
            q = rsp_rdata_i;
            cmd_valid_o = 1'b0;
            cmd_wdata_o = ~cmd_wdata_o; // released data never shows the last value
        end
    endtask
endmodule

// >>> test_fault_threshold_registers.sv
// self-checking bench for the fault limit bank
`timescale 1ns/1ps
`include "fault_limits_defines.vh"

`define CHK(nm, exp, got) begin tests_run = tests_run + 1; if ((got) !== (exp)) begin \
    error_cnt = error_cnt + 1; $display("unexpected %s: expected %h seen %h", nm, exp, got); end end

module test_fault_threshold_registers;
    localparam [47:0] CODES = {`CMD_OUT_OV_LIMIT, `CMD_OUT_UV_LIMIT, `CMD_STAGE_OT_LIMIT,
                               `CMD_OVERTEMP_WARNING_LIMIT, `CMD_IN_OV_LIMIT, `CMD_IN_UV_LIMIT};
    localparam [95:0] RSTS  = {`RST_OUT_OV_LIMIT, `RST_OUT_UV_LIMIT, `RST_STAGE_OT_LIMIT,
                               `RST_OVERTEMP_WARNING_LIMIT, `RST_IN_OV_LIMIT, `RST_IN_UV_LIMIT};
    reg         clk_i, srst_i, ce_i, v, e;
    reg  [31:0] vout_meas, temp_meas;
    reg  [15:0] vin_meas, q;
    reg  [1:0]  out_enable, out_ramp;
    wire        cmd_valid, cmd_write, cmd_page, rsp_valid, rsp_err;
    wire [7:0]  cmd_code, status_byte;
    wire [1:0]  cmd_len, vout_ov, vout_uv, ot_fault, ot_warn;
    wire [15:0] cmd_wdata, rsp_rdata, status_word, temp_status;
    wire        vin_ov, vin_lockout, alert, thermal_warn;
    integer     error_cnt, tests_run, cyc, i, pg;

    fault_threshold_registers dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid),
        .cmd_write_i(cmd_write), .cmd_code_i(cmd_code), .cmd_len_i(cmd_len),
        .cmd_page_i(cmd_page), .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid),
        .rsp_err_o(rsp_err), .rsp_rdata_o(rsp_rdata), .vout_meas_i(vout_meas),
        .temp_meas_i(temp_meas), .vin_meas_i(vin_meas), .out_enable_i(out_enable),
        .out_ramp_i(out_ramp), .vout_ov_o(vout_ov), .vout_uv_o(vout_uv), .ot_fault_o(ot_fault),
        .ot_warn_o(ot_warn), .vin_ov_o(vin_ov), .vin_lockout_o(vin_lockout),
        .status_byte_o(status_byte), .status_word_o(status_word), .temp_status_o(temp_status),
        .alert_o(alert), .thermal_warn_o(thermal_warn));

    limit_host_model host_u (
        .clk_i(clk_i), .rsp_valid_i(rsp_valid), .rsp_err_i(rsp_err), .rsp_rdata_i(rsp_rdata),
        .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write), .cmd_code_o(cmd_code),
        .cmd_len_o(cmd_len), .cmd_page_o(cmd_page), .cmd_wdata_o(cmd_wdata));

    // bus level helpers
    task rd(input [7:0] c, input p, input [15:0] x);
        begin
            host_u.xfer(1'b0, c, `LIMIT_DATA_BYTES, p, 16'h0000, v, e, q);
            `CHK("read ack", 2'b10, {v, e})
            `CHK("read data", x, q)
        end
    endtask
    task wr(input [7:0] c, input p, input [15:0] d);
        begin
            host_u.xfer(1'b1, c, `LIMIT_DATA_BYTES, p, d, v, e, q);
            `CHK("write ack", 2'b10, {v, e})
        end
    endtask
    task bad(input w, input [7:0] c, input [1:0] n);
        begin
            host_u.xfer(w, c, n, 1'b1, 16'h1234, v, e, q);
            `CHK("refusal", 2'b11, {v, e})
        end
    endtask
    task commit_all;
        begin
            host_u.xfer(1'b1, `CMD_COMMIT_SETTINGS, `COMMIT_DATA_BYTES, 1'b0, 16'h0000, v, e, q);
            `CHK("commit ack", 2'b10, {v, e})
        end
    endtask
    task settle;
        repeat (2) @(negedge clk_i);
    endtask
    task wrap_up;
        begin
            if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask

    // 20 MHz clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc = cyc + 1;
        if (cyc >= 2000) begin
            error_cnt = error_cnt + 1;
            wrap_up;
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {error_cnt, tests_run, cyc} = 0;
        {srst_i, ce_i} = 2'b11;
        vout_meas = {16'h0700, 16'h0700};
        temp_meas = {16'h0019, 16'h0019};
        vin_meas = 16'h2EE0;
        {out_enable, out_ramp} = 4'h0;
        repeat (2) @(negedge clk_i);
        srst_i = 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            for (pg = 0; pg < 2; pg = pg + 1) begin
                rd(CODES[40-8*i +: 8], pg[0], RSTS[80-16*i +: 16]);
            end
        end
        settle;
        `CHK("quiet outputs", 8'h00, {vout_ov, vout_uv, ot_fault, ot_warn})
        `CHK("quiet pins", 4'h0, {vin_ov, vin_lockout, alert, thermal_warn})
        // pending limits, paging, then commit
        wr(`CMD_OUT_OV_LIMIT, 1'b1, 16'h0600);
        rd(`CMD_OUT_OV_LIMIT, 1'b0, `RST_OUT_OV_LIMIT);
        wr(`CMD_IN_OV_LIMIT, 1'b1, 16'h2710);
        wr(`CMD_IN_UV_LIMIT, 1'b0, 16'h2EE1);
        rd(`CMD_IN_OV_LIMIT, 1'b0, 16'h2710);
        rd(`CMD_IN_UV_LIMIT, 1'b1, 16'h2EE1);
        settle;
        `CHK("flags before commit", 4'h0, {vout_ov, vin_ov, vin_lockout})
        commit_all;
        settle;
        `CHK("committed flags", 4'hB, {vout_ov, vin_ov, vin_lockout})
        `CHK("summary", 17'h100A8, {alert, status_word})
        wr(`CMD_OUT_OV_LIMIT, 1'b1, `RST_OUT_OV_LIMIT);
        wr(`CMD_IN_OV_LIMIT, 1'b0, `RST_IN_OV_LIMIT);
        wr(`CMD_IN_UV_LIMIT, 1'b0, `RST_IN_UV_LIMIT);
        commit_all;
        settle;
        `CHK("restored", 9'h000, {alert, status_byte})
        // undervoltage and its masking
        wr(`CMD_OUT_UV_LIMIT, 1'b0, 16'h0701);
        out_enable = 2'b11;
        settle;
        `CHK("uv live", 2'b01, vout_uv)
        out_ramp = 2'b01;
        settle;
        `CHK("uv ramping", 2'b00, vout_uv)
        {out_enable, out_ramp} = 4'h0;
        settle;
        `CHK("uv disabled", 2'b00, vout_uv)
        // temperature fault, warning, signed compare
        temp_meas[31:16] = 16'h007E;
        settle;
        `CHK("stage fault", 4'b1000, {ot_fault, ot_warn})
        wr(`CMD_OVERTEMP_WARNING_LIMIT, 1'b1, 16'h007D);
        settle;
        `CHK("warn pins", 4'b1011, {ot_warn, thermal_warn, alert})
        `CHK("warn status", 40'hC000000404, {temp_status, status_word, status_byte})
        temp_meas[31:16] = 16'hFFF0;
        settle;
        `CHK("negative temp", 6'h00, {ot_fault, ot_warn, thermal_warn, alert})
        // refused requests leave state alone
        bad(1'b1, `CMD_OUT_OV_LIMIT, 2'h1);
        bad(1'b1, 8'h41, `LIMIT_DATA_BYTES);
        bad(1'b0, `CMD_COMMIT_SETTINGS, `COMMIT_DATA_BYTES);
        bad(1'b1, `CMD_COMMIT_SETTINGS, `LIMIT_DATA_BYTES);
        rd(`CMD_OUT_OV_LIMIT, 1'b1, `RST_OUT_OV_LIMIT);
        // frozen block takes no request
        settle;
        ce_i = 1'b0;
        host_u.xfer(1'b0, `CMD_OUT_UV_LIMIT, `LIMIT_DATA_BYTES, 1'b0, 16'h0000, v, e, q);
        `CHK("ignored when frozen", 1'b0, v)
        ce_i = 1'b1;
        settle;
        wrap_up;
    end
endmodule

bind fault_threshold_registers fault_threshold_registers_properties #(.PAGES(PAGES), .DW(DW)) chk_u (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
    .cmd_write_i(cmd_write_i), .cmd_code_i(cmd_code_i), .cmd_len_i(cmd_len_i),
    .cmd_wdata_i(cmd_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
    .vin_meas_i(vin_meas_i), .out_enable_i(out_enable_i), .out_ramp_i(out_ramp_i),
    .vout_ov_o(vout_ov_o), .vout_uv_o(vout_uv_o), .ot_warn_o(ot_warn_o), .vin_ov_o(vin_ov_o),
    .vin_lockout_o(vin_lockout_o), .status_byte_o(status_byte_o),
    .status_word_o(status_word_o), .temp_status_o(temp_status_o), .alert_o(alert_o),
    .thermal_warn_o(thermal_warn_o));
